// File: design/pfm_pin_mux.sv
// pin-function mux: external bus on ports zero and two, code steering,
// external interrupt flags and counter-array pin routing.
// assumes the core raises one bus request at a time while bus_idle_out is high,
// and that all pin inputs are already synchronous to ref_clk_in.
//
// How it works
// R01: ale pulses one cycle at each external cycle start with address on the pins.
// R02: non-page mode keeps the high address byte on port two all cycle.
// R03: non-page mode carries low address then data on port zero.
// R04: page mode holds low address on port zero, data moves to port two.
// R05: strap low sends every code fetch off-chip.
// R06: strap high fetches on-chip below the on-chip size, off-chip above.
// R07: strap is captured during reset and held until the next reset.
// R08: board ties the strap low on parts without on-chip code.
// R09: edge-select set means a falling pin edge sets the flag.
// R10: edge-select clear means a low pin sets the flag every cycle.
// R11: port zero as gpio is open drain with no pullup.
// R12: ports one and two as gpio are quasi bidirectional with pullups.
// R13: counter-array pins are inputs for capture, driven for compare and pwm.
// R14: counter-array external clock pin can tick the counter-array timer.
// R15: programmer puts the program pulse on the ale pin.
// R16: code read strobe only for the range chosen in configuration byte zero.
// R17: external data reads use the port-three read strobe.
// R18: outside bus cycles ports zero and two go back to gpio.
`timescale 1ns/1ns
module pfm_pin_mux (
   input wire logic ref_clk_in, // core clock, 100 MHz
   input wire logic resetn_in, // synchronous reset, active low
   // core bus request side
   input wire logic bus_req_in, // one-cycle request pulse
   input wire logic [15:0] bus_addr_in, // request address
   input wire logic [7:0] bus_wdata_in, // write data
   input wire logic bus_write_in, // 1 data write, 0 read
   input wire logic bus_code_in, // 1 code fetch, 0 data access
   input wire logic page_mode_in, // page mode configuration
   input wire logic [7:0] user_config_byte_zero_in, // configuration byte zero
   output logic bus_idle_out, // ready for a request
   output logic bus_done_out, // external cycle finished, pulse
   output logic bus_onchip_out, // fetch served on-chip, pulse
   output logic [7:0] bus_rdata_out, // byte read by the last cycle
   // strap
   input wire logic ext_code_select_strap_in, // external-code strap pin
   output logic strap_latched_out, // strap value since reset
   // gpio latches from the core
   input wire logic [7:0] p0_gpio_in, // port zero latch
   input wire logic [7:0] p1_gpio_in, // port one latch
   input wire logic [7:0] p2_gpio_in, // port two latch
   // pins
   input wire logic [7:0] port_zero_pins_in, // port zero level
   output logic [7:0] port_zero_pins_out, // port zero drive value
   output logic [7:0] port_zero_pins_oe_n_out, // port zero enable, low drives
   input wire logic [7:0] port_one_pins_in, // port one level
   output logic [7:0] port_one_pins_out, // port one drive value
   output logic [7:0] port_one_pins_oe_n_out, // port one enable, low drives
   input wire logic [7:0] port_two_pins_in, // port two level
   output logic [7:0] port_two_pins_out, // port two drive value
   output logic [7:0] port_two_pins_oe_n_out, // port two enable, low drives
   output logic [2:0] port_pullup_en_out, // weak pullup per port
   output logic addr_latch_strobe_out, // address latch strobe, high
   output logic code_read_strobe_n_out, // code read strobe, low
   output logic data_read_strobe_n_out, // data read strobe, low
   output logic data_write_strobe_n_out, // data write strobe, low
   // external interrupts
   input wire logic [1:0] ext_irq_pins_in, // interrupt pins, active low
   input wire logic [1:0] ext_irq_edge_select_in, // edge-select bits
   input wire logic [1:0] ext_irq_clear_in, // flag clear pulses
   output logic [1:0] ext_irq_flags_out, // request flags
   // counter array
   input wire logic [4:0] ca_pin_alt_in, // pin used by the counter array
   input wire logic [4:0] ca_pin_drive_in, // 1 compare or pwm, 0 capture
   input wire logic [4:0] ca_pin_level_in, // compare or pwm output level
   output logic [4:0] counter_array_io_pins_capture_out, // sampled pin levels
   input wire logic ca_ext_clock_sel_in, // 1 tick from the external clock pin
   input wire logic ca_int_tick_in, // internal tick pulse
   output logic ca_tick_out // counter-array timer tick, pulse
);

   ////////////////////////////////////////////////////////////////////////////
   // bus cycle sequencer

   pfm_pkg::pfm_bus_state_t state_reg;
   pfm_pkg::pfm_bus_state_t state_next;
   logic [15:0] addr_reg;
   logic [7:0] wdata_reg;
   logic [7:0] rdata_reg;
   logic write_reg;
   logic code_reg;
   logic page_reg;
   logic code_read_strobe_ok_reg;
   logic done_reg;
   logic onchip_reg;

   pfm_steer_if st_if ();

   wire req_take;
   wire go_ext;
   wire in_addr;
   wire in_strobe;
   wire on_bus;

   assign req_take = bus_req_in && (state_reg == pfm_pkg::PFM_IDLE);
   assign go_ext = req_take && (!bus_code_in || st_if.offchip); // R05 R06
   assign in_addr = (state_reg == pfm_pkg::PFM_ADDR);
   assign in_strobe = (state_reg == pfm_pkg::PFM_STROBE);
   assign on_bus = in_addr || in_strobe;

   assign st_if.fetch_addr = bus_addr_in;
   assign st_if.range_sel = user_config_byte_zero_in[pfm_pkg::CFG_RANGE_LSB +: 2];

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         pfm_pkg::PFM_IDLE: begin
            if (go_ext) begin
               state_next = pfm_pkg::PFM_ADDR;
            end
         end
         pfm_pkg::PFM_ADDR: state_next = pfm_pkg::PFM_STROBE;
         pfm_pkg::PFM_STROBE: state_next = pfm_pkg::PFM_IDLE;
         default: state_next = pfm_pkg::PFM_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         state_reg <= pfm_pkg::PFM_IDLE;
         done_reg <= 1'b0;
         onchip_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         done_reg <= in_strobe;
         onchip_reg <= req_take && !go_ext;
      end
   end

   // request fields are held for the whole cycle, so the core may move on
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         addr_reg <= pfm_pkg::ADDR_RESET;
         wdata_reg <= pfm_pkg::BYTE_RESET;
         write_reg <= 1'b0;
         code_reg <= 1'b0;
         page_reg <= 1'b0;
         code_read_strobe_ok_reg <= 1'b0;
      end else if (req_take) begin
         addr_reg <= bus_addr_in;
         wdata_reg <= bus_wdata_in;
         write_reg <= bus_write_in && !bus_code_in;
         code_reg <= bus_code_in;
         page_reg <= page_mode_in;
         code_read_strobe_ok_reg <= st_if.code_read_strobe_allowed; // R16
      end
   end

   // page mode returns data on port two, otherwise on port zero
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         rdata_reg <= pfm_pkg::BYTE_RESET;
      end else if (in_strobe && !write_reg) begin
         rdata_reg <= page_reg ? port_two_pins_in : port_zero_pins_in;
      end
   end

   assign bus_idle_out = (state_reg == pfm_pkg::PFM_IDLE);
   assign bus_done_out = done_reg;
   assign bus_onchip_out = onchip_reg;
   assign bus_rdata_out = rdata_reg;

   ////////////////////////////////////////////////////////////////////////////
   // strobes

   assign addr_latch_strobe_out = in_addr; // R01
   assign code_read_strobe_n_out = !(in_strobe && code_reg && code_read_strobe_ok_reg); // R16
   assign data_read_strobe_n_out = !(in_strobe && !code_reg && !write_reg); // R17
   assign data_write_strobe_n_out = !(in_strobe && write_reg);

   ////////////////////////////////////////////////////////////////////////////
   // port zero and port two

   wire p0_drive_bus;
   wire p2_drive_bus;
   wire [7:0] p0_bus_val;
   wire [7:0] p2_bus_val;

   // a read strobe releases the data port so the memory can answer
   assign p0_drive_bus = in_addr || page_reg || write_reg; // R03 R04
   assign p0_bus_val = (in_addr || page_reg) ? addr_reg[7:0] : wdata_reg; // R03 R04
   assign p2_drive_bus = in_addr || !page_reg || write_reg; // R02 R04
   assign p2_bus_val = (in_addr || !page_reg) ? addr_reg[15:8] : wdata_reg; // R02 R04

   // gpio on port zero only ever pulls low: no pullup to drive a one
   assign port_zero_pins_out = on_bus ? p0_bus_val : pfm_pkg::BYTE_RESET; // R11 R18
   assign port_zero_pins_oe_n_out = on_bus ? (p0_drive_bus ? 8'h00 : 8'hff) : p0_gpio_in; // R11 R18
   assign port_two_pins_out = on_bus ? p2_bus_val : pfm_pkg::BYTE_RESET; // R12 R18
   assign port_two_pins_oe_n_out = on_bus ? (p2_drive_bus ? 8'h00 : 8'hff) : p2_gpio_in; // R12 R18
   assign port_pullup_en_out = pfm_pkg::PULLUP_EN; // R11 R12

   ////////////////////////////////////////////////////////////////////////////
   // port one and counter array

   logic [4:0] cap_reg;
   logic eci_prev_reg;
   logic tick_reg;
   wire eci_rise;

   assign port_one_pins_out[pfm_pkg::CA_PIN_LSB - 1:0] = pfm_pkg::BYTE_RESET[pfm_pkg::CA_PIN_LSB - 1:0];
   assign port_one_pins_oe_n_out[pfm_pkg::CA_PIN_LSB - 1:0] = p1_gpio_in[pfm_pkg::CA_PIN_LSB - 1:0]; // R12

   genvar k;
   generate
      for (k = 0; k < pfm_pkg::CA_PINS; k++) begin : g_ca
         localparam int PIN = pfm_pkg::CA_PIN_LSB + k;
         wire drive_w = ca_pin_alt_in[k] && ca_pin_drive_in[k];
         wire listen_w = ca_pin_alt_in[k] && !ca_pin_drive_in[k];
         assign port_one_pins_out[PIN] = drive_w && ca_pin_level_in[k]; // R13
         assign port_one_pins_oe_n_out[PIN] = listen_w || (!drive_w && p1_gpio_in[PIN]); // R13 R12
         always_ff @(posedge ref_clk_in) begin
            if (!resetn_in) begin
               cap_reg[k] <= pfm_pkg::CA_RESET[k];
            end else begin
               cap_reg[k] <= port_one_pins_in[PIN]; // R13
            end
         end
      end
   endgenerate

   assign counter_array_io_pins_capture_out = cap_reg;

   // the external clock pin sits just below the first counter-array pin
   assign eci_rise = port_one_pins_in[pfm_pkg::CA_PIN_LSB - 1] && !eci_prev_reg;

   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         eci_prev_reg <= 1'b1;
         tick_reg <= 1'b0;
      end else begin
         eci_prev_reg <= port_one_pins_in[pfm_pkg::CA_PIN_LSB - 1];
         tick_reg <= ca_ext_clock_sel_in ? eci_rise : ca_int_tick_in; // R14
      end
   end

   assign ca_tick_out = tick_reg;

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   pfm_code_steer u_steer (
      .ref_clk_in(ref_clk_in),
      .resetn_in(resetn_in),
      .strap_in(ext_code_select_strap_in),
      .strap_latched_out(strap_latched_out),
      .st(st_if.steer)
   );

   pfm_ext_irq u_irq (
      .ref_clk_in(ref_clk_in),
      .resetn_in(resetn_in),
      .pins_in(ext_irq_pins_in),
      .edge_sel_in(ext_irq_edge_select_in),
      .clear_in(ext_irq_clear_in),
      .flags_out(ext_irq_flags_out)
   );

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);

   property p_ale_pulse;
      go_ext |=> addr_latch_strobe_out && (port_two_pins_out == $past(bus_addr_in[15:8]))
             ##1 !addr_latch_strobe_out;
   endproperty
   a_ale_pulse: assert property (p_ale_pulse) else $error("ale missing or too long"); // R01

   property p_np_high_addr;
      in_strobe && !page_reg |-> (port_two_pins_out == addr_reg[15:8]) && (port_two_pins_oe_n_out == 8'h00);
   endproperty
   a_np_high_addr: assert property (p_np_high_addr) else $error("port two lost high address"); // R02

   property p_np_data;
      go_ext && bus_write_in && !bus_code_in && !page_mode_in
         |=> (port_zero_pins_out == $past(bus_addr_in[7:0])) ##1 (port_zero_pins_out == $past(bus_wdata_in, 2));
   endproperty
   a_np_data: assert property (p_np_data) else $error("port zero address then data wrong"); // R03

   property p_page_split;
      in_strobe && page_reg && write_reg |-> (port_zero_pins_out == addr_reg[7:0]) && (port_two_pins_out == wdata_reg);
   endproperty
   a_page_split: assert property (p_page_split) else $error("page mode ports wrong"); // R04

   property p_code_read_strobe_range;
      !code_read_strobe_n_out |-> $past(in_addr) && code_reg && code_read_strobe_ok_reg;
   endproperty
   a_code_read_strobe_range: assert property (p_code_read_strobe_range) else $error("code strobe outside range"); // R16

   property p_rd_data;
      !data_read_strobe_n_out |-> $past(in_addr) && !code_reg && code_read_strobe_n_out;
   endproperty
   a_rd_data: assert property (p_rd_data) else $error("data read strobe misused"); // R17

   property p_idle_gpio;
      bus_idle_out |-> (port_zero_pins_oe_n_out == p0_gpio_in) && (port_two_pins_oe_n_out == p2_gpio_in)
                       && (port_zero_pins_out == 8'h00) && !port_pullup_en_out[0];
   endproperty
   a_idle_gpio: assert property (p_idle_gpio) else $error("ports not returned to gpio"); // R18 R11

   property p_ca_capture;
      ((port_one_pins_oe_n_out[7:3] & ca_pin_alt_in & ~ca_pin_drive_in) == (ca_pin_alt_in & ~ca_pin_drive_in))
      && ((port_one_pins_oe_n_out[7:3] & ca_pin_alt_in & ca_pin_drive_in) == 5'h00);
   endproperty
   a_ca_capture: assert property (p_ca_capture) else $error("counter-array pin direction wrong"); // R13

   property p_eci_tick;
      ca_ext_clock_sel_in && $rose(port_one_pins_in[2]) |=> ca_tick_out;
   endproperty
   a_eci_tick: assert property (p_eci_tick) else $error("external clock edge gave no tick"); // R14

endmodule : pfm_pin_mux

// File: design/pfm_pkg.sv
// constants and types shared by the pin-function mux and its helpers.
// assumes one core clock and a synchronous active-low reset.
package pfm_pkg;

   // on-chip code size; fetches at or above it go off-chip
   localparam logic [15:0] ONCHIP_CODE_BYTES = 16'h4000;

   // position of the two-bit code range field in configuration byte zero
   localparam int CFG_RANGE_LSB = 2;

   // code range field encodings
   localparam logic [1:0] RANGE_NONE = 2'h0;
   localparam logic [1:0] RANGE_LOW = 2'h1;
   localparam logic [1:0] RANGE_HIGH = 2'h2;
   localparam logic [1:0] RANGE_ALL = 2'h3;

   // pullup enables per port: bit 0 port zero, bit 1 port one, bit 2 port two
   localparam logic [2:0] PULLUP_EN = 3'h6;

   // idle level of the interrupt pins, used for edge history after reset
   localparam logic [1:0] IRQ_PIN_IDLE = 2'h3;

   // values after reset
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [15:0] ADDR_RESET = 16'h0000;
   localparam logic [4:0] CA_RESET = 5'h00;

   // first counter-array pin on port one
   localparam int CA_PIN_LSB = 3;
   localparam int CA_PINS = 5;

   typedef enum logic [1:0] {
      PFM_IDLE,
      PFM_ADDR,
      PFM_STROBE
   } pfm_bus_state_t;

endpackage : pfm_pkg

// File: design/pfm_steer_if.sv
// carries a code fetch address to the steering helper and its verdict back.
// assumes both ends sit on the same core clock.
`timescale 1ns/1ns
interface pfm_steer_if;
   logic [15:0] fetch_addr;
   logic [1:0] range_sel;
   logic offchip;
   logic code_read_strobe_allowed;

   modport top (output fetch_addr, output range_sel, input offchip, input code_read_strobe_allowed);
   modport steer (input fetch_addr, input range_sel, output offchip, output code_read_strobe_allowed);
endinterface : pfm_steer_if

// File: design/pfm_code_steer.sv
// latches the external-code strap at reset and decides where a fetch goes.
// assumes the strap input is steady while reset is held.
`timescale 1ns/1ns
module pfm_code_steer (
   input wire logic ref_clk_in, // core clock
   input wire logic resetn_in, // synchronous reset, active low
   input wire logic strap_in, // external-code strap pin
   output logic strap_latched_out, // strap value held since reset
   pfm_steer_if.steer st // fetch address and verdict
);

   logic strap_reg;
   wire above_onchip;
   wire in_range;

   // sync reset: the flop simply follows the pin while reset is held
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         strap_reg <= strap_in; // R07
      end
   end

   assign strap_latched_out = strap_reg;
   assign above_onchip = (st.fetch_addr >= pfm_pkg::ONCHIP_CODE_BYTES);
   assign st.offchip = !strap_reg || above_onchip; // R05 R06

   assign in_range = (st.range_sel == pfm_pkg::RANGE_ALL) ||
                     ((st.range_sel == pfm_pkg::RANGE_LOW) && !st.fetch_addr[15]) ||
                     ((st.range_sel == pfm_pkg::RANGE_HIGH) && st.fetch_addr[15]);
   assign st.code_read_strobe_allowed = in_range; // R16

   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);

   property p_strap_low_offchip;
      !strap_reg |-> st.offchip;
   endproperty
   a_strap_low_offchip: assert property (p_strap_low_offchip) else $error("strap low but fetch on-chip"); // R05

   property p_strap_high_split;
      strap_reg |-> (st.offchip == (st.fetch_addr >= pfm_pkg::ONCHIP_CODE_BYTES));
   endproperty
   a_strap_high_split: assert property (p_strap_high_split) else $error("on-chip split wrong"); // R06

   property p_strap_held;
      resetn_in && $past(resetn_in) |-> $stable(strap_reg);
   endproperty
   a_strap_held: assert property (p_strap_held) else $error("strap changed outside reset"); // R07

endmodule : pfm_code_steer

// File: design/pfm_ext_irq.sv
// two external interrupt request flags, edge or level triggered.
// assumes pins are synchronous to the core clock.
`timescale 1ns/1ns
module pfm_ext_irq (
   input wire logic ref_clk_in, // core clock
   input wire logic resetn_in, // synchronous reset, active low
   input wire logic [1:0] pins_in, // interrupt pins, active low
   input wire logic [1:0] edge_sel_in, // 1 falling edge, 0 low level
   input wire logic [1:0] clear_in, // flag clear pulses from the core
   output logic [1:0] flags_out // request flags
);

   logic [1:0] prev_reg;
   logic [1:0] flag_reg;
   wire [1:0] set_w;

   genvar i;
   generate
      for (i = 0; i < 2; i++) begin : g_irq
         assign set_w[i] = edge_sel_in[i] ? (prev_reg[i] && !pins_in[i]) : !pins_in[i]; // R09 R10
         // set beats clear so a request in the clear cycle survives
         always_ff @(posedge ref_clk_in) begin
            if (!resetn_in) begin
               prev_reg[i] <= pfm_pkg::IRQ_PIN_IDLE[i];
               flag_reg[i] <= 1'b0;
            end else begin
               prev_reg[i] <= pins_in[i];
               flag_reg[i] <= set_w[i] || (flag_reg[i] && !clear_in[i]);
            end
         end
      end
   endgenerate

   assign flags_out = flag_reg;

   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);

   property p_edge_sets;
      edge_sel_in[0] && $fell(pins_in[0]) |=> flags_out[0];
   endproperty
   a_edge_sets: assert property (p_edge_sets) else $error("falling edge did not set flag 0"); // R09

   property p_edge_no_level;
      edge_sel_in[1] && !pins_in[1] && !$past(pins_in[1]) && clear_in[1] |=> !flags_out[1];
   endproperty
   a_edge_no_level: assert property (p_edge_no_level) else $error("held low set edge flag 1"); // R09

   property p_level_sets;
      !edge_sel_in[1] && !pins_in[1] |=> flags_out[1];
   endproperty
   a_level_sets: assert property (p_level_sets) else $error("low level did not set flag 1"); // R10

endmodule : pfm_ext_irq

// File: tb/pfm_ext_mem.sv
// external memory with an address latch, on the far side of the pin mux.
// assumes the bench resolves the port levels and feeds them back here.
`timescale 1ns/1ns
module pfm_ext_mem (
   input wire logic clk_in, // core clock
   input wire logic ale_in, // address latch strobe
   input wire logic page_in, // page mode wiring
   input wire logic [7:0] p0_in, // port zero level
   input wire logic [7:0] p2_in, // port two level
   input wire logic code_n_in, // code read strobe, low
   input wire logic rd_n_in, // data read strobe, low
   input wire logic wr_n_in, // data write strobe, low
   output logic drv0_out, // drives port zero
   output logic drv2_out, // drives port two
   output logic [7:0] data_out // byte driven on a read
);
   logic [7:0] lo_reg, hi_reg;
   logic [7:0] mem [256];
   wire logic [7:0] idx = lo_reg ^ hi_reg;
   wire logic rd = !code_n_in || !rd_n_in;
   always @(posedge clk_in) begin
      if (ale_in) begin
         lo_reg <= p0_in;
         hi_reg <= p2_in;
      end
      if (!wr_n_in) mem[idx] <= page_in ? p2_in : p0_in;
   end
   // data only stands while a read strobe is low
   assign drv0_out = rd && !page_in;
   assign drv2_out = rd && page_in;
   assign data_out = mem[idx];
endmodule : pfm_ext_mem

// File: tb/test_mcu_pin_function_mux.sv
// self-checking bench for the pin-function mux with an external memory.
// assumes the pfm_pkg package and the design files are compiled first.
`timescale 1ns/1ns
module test_mcu_pin_function_mux;
   logic ref_clk_in = 1'b0, resetn_in = 1'b0, bus_req_in = 1'b0, bus_write_in, bus_code_in, page_mode_in;
   logic [15:0] bus_addr_in;
   logic [7:0] bus_wdata_in, user_config_byte_zero_in = 8'h0c, p0_gpio_in = 8'hf0;
   logic [7:0] p1_gpio_in = 8'hff, p2_gpio_in = 8'h0f, p1_ext = 8'hff, flt = 8'h00;
   logic ext_code_select_strap_in = 1'b0, strap_latched_out, bus_idle_out, bus_done_out, bus_onchip_out;
   logic [7:0] bus_rdata_out, port_zero_pins_in, port_zero_pins_out, port_zero_pins_oe_n_out;
   logic [7:0] port_one_pins_in, port_one_pins_out, port_one_pins_oe_n_out;
   logic [7:0] port_two_pins_in, port_two_pins_out, port_two_pins_oe_n_out, m_data;
   logic [2:0] port_pullup_en_out;
   logic addr_latch_strobe_out, code_read_strobe_n_out, data_read_strobe_n_out, data_write_strobe_n_out;
   logic [1:0] ext_irq_pins_in = 2'h3, ext_irq_edge_select_in = 2'h3, ext_irq_clear_in = 2'h0, ext_irq_flags_out;
   logic [4:0] ca_pin_alt_in = 5'h00, ca_pin_drive_in = 5'h00, ca_pin_level_in = 5'h00;
   logic [4:0] counter_array_io_pins_capture_out;
   logic ca_ext_clock_sel_in = 1'b0, ca_int_tick_in = 1'b0, ca_tick_out, m_drv0, m_drv2, seen;
   int failures = 0, tests_run = 0;
   ////////////////////////////////////////////////////////////////////////////
   always #5 ref_clk_in = ~ref_clk_in;
   // released port zero has no pullup, so it shows a changing pattern
   always @(posedge ref_clk_in) flt <= flt + 8'h35;
   assign port_zero_pins_in = (~port_zero_pins_oe_n_out & port_zero_pins_out) |
                              (port_zero_pins_oe_n_out & (m_drv0 ? m_data : flt));
   assign port_two_pins_in = (~port_two_pins_oe_n_out & port_two_pins_out) |
                             (port_two_pins_oe_n_out & (m_drv2 ? m_data : 8'hff));
   assign port_one_pins_in = (~port_one_pins_oe_n_out & port_one_pins_out) | (port_one_pins_oe_n_out & p1_ext);
   pfm_pin_mux i_dut (.ref_clk_in, .resetn_in, .bus_req_in, .bus_addr_in, .bus_wdata_in, .bus_write_in,
      .bus_code_in, .page_mode_in, .user_config_byte_zero_in, .bus_idle_out, .bus_done_out, .bus_onchip_out,
      .bus_rdata_out, .ext_code_select_strap_in, .strap_latched_out, .p0_gpio_in, .p1_gpio_in, .p2_gpio_in,
      .port_zero_pins_in, .port_zero_pins_out, .port_zero_pins_oe_n_out, .port_one_pins_in, .port_one_pins_out,
      .port_one_pins_oe_n_out, .port_two_pins_in, .port_two_pins_out, .port_two_pins_oe_n_out,
      .port_pullup_en_out, .addr_latch_strobe_out, .code_read_strobe_n_out, .data_read_strobe_n_out,
      .data_write_strobe_n_out, .ext_irq_pins_in, .ext_irq_edge_select_in, .ext_irq_clear_in, .ext_irq_flags_out,
      .ca_pin_alt_in, .ca_pin_drive_in, .ca_pin_level_in, .counter_array_io_pins_capture_out,
      .ca_ext_clock_sel_in, .ca_int_tick_in, .ca_tick_out);
   pfm_ext_mem i_mem (.clk_in(ref_clk_in), .ale_in(addr_latch_strobe_out), .page_in(page_mode_in),
      .p0_in(port_zero_pins_in), .p2_in(port_two_pins_in), .code_n_in(code_read_strobe_n_out),
      .rd_n_in(data_read_strobe_n_out), .wr_n_in(data_write_strobe_n_out), .drv0_out(m_drv0),
      .drv2_out(m_drv2), .data_out(m_data));
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic complete_run;
      if (failures == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : complete_run
   task automatic do_reset(input logic s);
      @(negedge ref_clk_in);
      ext_code_select_strap_in = s;
      resetn_in = 1'b0;
      repeat (12) @(negedge ref_clk_in);
      resetn_in = 1'b1;
   endtask : do_reset
   // one request; d is write data, or the byte a data read must return
   task automatic bus_op(input logic [15:0] a, input logic [7:0] d, input logic wr, cd, pg, ext, ps);
      @(negedge ref_clk_in);
      bus_req_in = 1'b1;
      bus_addr_in = a;
      bus_wdata_in = d;
      bus_write_in = wr;
      bus_code_in = cd;
      page_mode_in = pg;
      @(negedge ref_clk_in);
      bus_req_in = 1'b0;
      if (!ext) begin
         check(bus_onchip_out, 1'b1);
         check(addr_latch_strobe_out, 1'b0);
         return;
      end
      check(addr_latch_strobe_out, 1'b1);
      check(port_zero_pins_out, a[7:0]);
      check(port_two_pins_out, a[15:8]);
      check(port_two_pins_oe_n_out, 8'h00);
      @(negedge ref_clk_in);
      check(cd ? code_read_strobe_n_out : wr ? data_write_strobe_n_out : data_read_strobe_n_out, cd ? !ps : 1'b0);
      if (pg) check(port_zero_pins_out, a[7:0]);
      if (wr) check(pg ? port_two_pins_out : port_zero_pins_out, d);
      @(negedge ref_clk_in);
      check(bus_done_out, 1'b1);
      check(port_zero_pins_oe_n_out, p0_gpio_in);
      check(port_two_pins_in, p2_gpio_in);
      if (!wr && !cd) check(bus_rdata_out, d);
   endtask : bus_op
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      bus_addr_in = 16'h0000;
      bus_wdata_in = 8'h00;
      bus_write_in = 1'b0;
      bus_code_in = 1'b0;
      page_mode_in = 1'b0;
      do_reset(1'b0);
      check(bus_idle_out, 1'b1);
      check(ext_irq_flags_out, 2'h0);
      check(port_pullup_en_out, 3'h6);
      check(addr_latch_strobe_out, 1'b0);
      ext_code_select_strap_in = 1'b1;
      @(negedge ref_clk_in);
      check(strap_latched_out, 1'b0);
      bus_op(16'h0100, 8'h00, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
      for (int r = 0; r < 4; r++) begin
         for (int h = 0; h < 2; h++) begin
            user_config_byte_zero_in = 8'(r) << pfm_pkg::CFG_RANGE_LSB;
            bus_op(h ? 16'h8000 : 16'h0100, 8'h00, 1'b0, 1'b1, 1'b0, 1'b1, r == 3 || r == h + 1);
         end
      end
      bus_op(16'h1234, 8'h5a, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
      bus_op(16'h1234, 8'h5a, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
      bus_op(16'h2345, 8'hc3, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
      bus_op(16'h2345, 8'hc3, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
      do_reset(1'b1);
      check(strap_latched_out, 1'b1);
      bus_op(16'h3fff, 8'h00, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
      bus_op(16'h4000, 8'h00, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
      // falling edge sets, a pin held low must not set again
      ext_irq_pins_in = 2'h0;
      @(negedge ref_clk_in);
      check(ext_irq_flags_out, 2'h3);
      ext_irq_clear_in = 2'h3;
      @(negedge ref_clk_in);
      ext_irq_clear_in = 2'h0;
      @(negedge ref_clk_in);
      check(ext_irq_flags_out, 2'h0);
      ext_irq_edge_select_in = 2'h0;
      ext_irq_clear_in = 2'h3;
      @(negedge ref_clk_in);
      ext_irq_clear_in = 2'h0;
      check(ext_irq_flags_out, 2'h3);
      ca_pin_alt_in = 5'h1f;
      ca_pin_drive_in = 5'h0f;
      ca_pin_level_in = 5'h05;
      ca_ext_clock_sel_in = 1'b1;
      p1_ext = 8'h7b;
      @(negedge ref_clk_in);
      check(port_one_pins_oe_n_out[7:3], 5'h10);
      check(port_one_pins_out[6:3], 4'h5);
      check(counter_array_io_pins_capture_out[4], 1'b0);
      p1_ext = 8'hff;
      seen = 1'b0;
      repeat (2) begin
         @(negedge ref_clk_in);
         seen = seen | ca_tick_out;
      end
      check(seen, 1'b1);
      ca_ext_clock_sel_in = 1'b0;
      ca_int_tick_in = 1'b1;
      @(negedge ref_clk_in);
      ca_int_tick_in = 1'b0;
      check(ca_tick_out, 1'b1);
      complete_run();
   end
endmodule : test_mcu_pin_function_mux
